/* File: shared/acp_pkg.sv */
package acp_pkg;
  localparam int ACP_ADDR_W = 4;
  localparam int ACP_DATA_W = 8;
  localparam int ACP_NUM_PINS = 16;

  // register map
  localparam logic [3:0] ACP_OFS_CONFIG = 4'h0;
  localparam logic [3:0] ACP_OFS_PIN_LOW = 4'h1;
  localparam logic [3:0] ACP_OFS_PIN_MID = 4'h2;
  localparam logic [3:0] ACP_OFS_STATUS = 4'h3;

  // configuration field positions
  localparam int ACP_BIT_LOW_POWER = 7;
  localparam int ACP_POS_DIVIDE = 5;
  localparam int ACP_BIT_LONG_SAMPLE = 4;
  localparam int ACP_POS_MODE = 2;
  localparam int ACP_POS_CLKSEL = 0;

  // reset values
  localparam logic [7:0] ACP_RST_CONFIG = 8'h00;
  localparam logic [7:0] ACP_RST_PIN = 8'h00;

  // read value of an unmapped offset
  localparam logic [7:0] ACP_UNMAPPED_READ = 8'h00;

  typedef enum logic [1:0] {
    ACP_DIV_1 = 2'b00,
    ACP_DIV_2 = 2'b01,
    ACP_DIV_4 = 2'b10,
    ACP_DIV_8 = 2'b11
  } acp_divide_t;

  typedef enum logic [1:0] {
    ACP_MODE_8BIT = 2'b00,
    ACP_MODE_RSV1 = 2'b01,
    ACP_MODE_10BIT = 2'b10,
    ACP_MODE_RSV3 = 2'b11
  } acp_mode_t;

  typedef enum logic [1:0] {
    ACP_CLK_BUS = 2'b00,
    ACP_CLK_BUS_HALF = 2'b01,
    ACP_CLK_ALT = 2'b10,
    ACP_CLK_ASYNC = 2'b11
  } acp_clksel_t;

  typedef struct packed {
    logic low_power_select;
    acp_divide_t clock_divide_select;
    logic long_sample_select;
    acp_mode_t mode_select;
    acp_clksel_t input_clock_select;
  } acp_config_t;

  typedef struct packed {
    logic [ACP_ADDR_W-1:0] addr;
    logic [ACP_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } acp_bus_req_t;

  typedef struct packed {
    logic output_hiz;
    logic input_disable;
    logic pullup_disable;
  } acp_pin_ctl_t;
endpackage

/* File: hw/acp_clk_divider.sv */
`timescale 1ns/10ps
module acp_clk_divider (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic src_tick,
  input wire acp_pkg::acp_divide_t divide,
  output logic div_tick
);
  import acp_pkg::*;

  logic [2:0] count;
  logic [2:0] next_count;
  logic next_div_tick;
  logic [2:0] limit;

  always_comb begin
    limit = 3'h0;
    unique case (divide)
      ACP_DIV_1: limit = 3'h0;
      ACP_DIV_2: limit = 3'h1;
      ACP_DIV_4: limit = 3'h3;
      ACP_DIV_8: limit = 3'h7;
    endcase
    next_count = count;
    next_div_tick = 1'b0;
    if (src_tick) begin
      if (count >= limit) begin
        // >= so a shrinking divide never strands the counter above its limit
        next_count = 3'h0;
        next_div_tick = 1'b1;
      end else begin
        next_count = count + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= 3'h0;
      div_tick <= 1'b0;
    end else begin
      count <= next_count;
      div_tick <= next_div_tick;
    end
  end
endmodule

/* File: hw/acp_pin_gate.sv */
`timescale 1ns/10ps
module acp_pin_gate (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic disable_bit,
  input wire logic port_in,
  output acp_pkg::acp_pin_ctl_t ctl,
  output logic port_read
);
  import acp_pkg::*;

  acp_pin_ctl_t next_ctl;
  logic next_port_read;

  always_comb begin
    next_ctl.output_hiz = disable_bit;
    next_ctl.input_disable = disable_bit;
    next_ctl.pullup_disable = disable_bit;
    next_port_read = disable_bit ? 1'b0 : port_in;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl <= '0;
      port_read <= 1'b0;
    end else begin
      ctl <= next_ctl;
      port_read <= next_port_read;
    end
  end
endmodule

/* File: hw/acp_adc_config.sv */
// Added by the designer: strobed register access and the address map.
`timescale 1ns/10ps
// Overview of operation
// - config bit 7: 0 high speed, 1 low power operating point
// - config bits 6:5 divide the converter clock by 1, 2, 4 or 8
// - config bit 4: 0 short sample time, 1 long sample time
// - config bits 3:2: 00 8-bit, 10 10-bit; 01 and 11 reserved
// - config bits 1:0 pick bus, bus/2, alternate or internal async clock
// - first pin register bit n controls channel n pin, channels 0 to 7
// - second pin register bit 0 is channel 8, bit 7 channel 15
// - pin bit 0 keeps port control, 1 removes port control
// - disabled pin: output high impedance, input reads zero, pullup off
// - clock source is the bus clock after reset
// - changing the resolution invalidates any held result
module acp_adc_config #(
  parameter int NUM_PINS = acp_pkg::ACP_NUM_PINS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [acp_pkg::ACP_ADDR_W-1:0] reg_addr,
  input wire logic [acp_pkg::ACP_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic alternate_clock_source,
  input wire logic converter_async_clock,
  input wire logic result_written,
  input wire logic [NUM_PINS-1:0] port_in,
  output logic [acp_pkg::ACP_DATA_W-1:0] reg_rdata,
  output acp_pkg::acp_config_t cfg,
  output logic converter_clock,
  output logic result_invalid,
  output logic mode_reserved,
  output acp_pkg::acp_pin_ctl_t [NUM_PINS-1:0] pin_ctl,
  output logic [NUM_PINS-1:0] port_read
);
  import acp_pkg::*;

  // the pin map is exactly two 8-bit registers; any other width cannot be served
  if (NUM_PINS != 2 * ACP_DATA_W) begin : g_pins_check
    $error("NUM_PINS must equal two pin registers of data width");
  end

  acp_bus_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // register state
  acp_config_t next_cfg;
  logic [ACP_DATA_W-1:0] pin_low;
  logic [ACP_DATA_W-1:0] next_pin_low;
  logic [ACP_DATA_W-1:0] pin_mid;
  logic [ACP_DATA_W-1:0] next_pin_mid;
  logic next_result_invalid;
  logic [ACP_DATA_W-1:0] next_reg_rdata;
  logic next_mode_reserved;

  always_comb begin
    next_cfg = cfg;
    next_pin_low = pin_low;
    next_pin_mid = pin_mid;
    next_result_invalid = result_invalid;
    if (req.wr) begin
      unique case (req.addr)
        ACP_OFS_CONFIG: begin
          next_cfg.low_power_select = req.wdata[ACP_BIT_LOW_POWER];
          next_cfg.clock_divide_select = acp_divide_t'(req.wdata[ACP_POS_DIVIDE +: 2]);
          next_cfg.long_sample_select = req.wdata[ACP_BIT_LONG_SAMPLE];
          next_cfg.mode_select = acp_mode_t'(req.wdata[ACP_POS_MODE +: 2]);
          next_cfg.input_clock_select = acp_clksel_t'(req.wdata[ACP_POS_CLKSEL +: 2]);
        end
        ACP_OFS_PIN_LOW: next_pin_low = req.wdata;
        ACP_OFS_PIN_MID: next_pin_mid = req.wdata;
        default: ;
      endcase
    end
    // a fresh result clears the flag; a mode change in the same cycle wins
    if (result_written) begin
      next_result_invalid = 1'b0;
    end
    if (next_cfg.mode_select != cfg.mode_select) begin
      next_result_invalid = 1'b1;
    end
    // software is told not to use these codes; flag them rather than remap
    next_mode_reserved = (next_cfg.mode_select == ACP_MODE_RSV1) ||
                         (next_cfg.mode_select == ACP_MODE_RSV3);
  end

  always_comb begin
    next_reg_rdata = ACP_UNMAPPED_READ;
    if (req.rd) begin
      unique case (req.addr)
        ACP_OFS_CONFIG: next_reg_rdata = cfg;
        ACP_OFS_PIN_LOW: next_reg_rdata = pin_low;
        ACP_OFS_PIN_MID: next_reg_rdata = pin_mid;
        ACP_OFS_STATUS: next_reg_rdata = {6'h00, mode_reserved, result_invalid};
        default: next_reg_rdata = ACP_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg <= ACP_RST_CONFIG;
      pin_low <= ACP_RST_PIN;
      pin_mid <= ACP_RST_PIN;
      result_invalid <= 1'b0;
      mode_reserved <= 1'b0;
      reg_rdata <= ACP_UNMAPPED_READ;
    end else begin
      cfg <= next_cfg;
      pin_low <= next_pin_low;
      pin_mid <= next_pin_mid;
      result_invalid <= next_result_invalid;
      mode_reserved <= next_mode_reserved;
      reg_rdata <= next_reg_rdata;
    end
  end

  // clock source selection, expressed as enable ticks on clk
  logic bus_half;
  logic next_bus_half;
  logic alt_q;
  logic alt_q2;
  logic async_q;
  logic async_q2;
  logic src_tick;
  logic next_src_tick;
  logic div_tick;
  logic next_converter_clock;

  always_comb begin
    next_bus_half = ~bus_half;
    next_src_tick = 1'b0;
    unique case (cfg.input_clock_select)
      ACP_CLK_BUS: next_src_tick = 1'b1;
      ACP_CLK_BUS_HALF: next_src_tick = bus_half;
      // edges of slow outside clocks are caught after a two-stage sync
      ACP_CLK_ALT: next_src_tick = alt_q2 & ~alt_q;
      ACP_CLK_ASYNC: next_src_tick = async_q2 & ~async_q;
    endcase
  end

  logic alt_q3;
  logic async_q3;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus_half <= 1'b0;
      alt_q <= 1'b0;
      alt_q2 <= 1'b0;
      alt_q3 <= 1'b0;
      async_q <= 1'b0;
      async_q2 <= 1'b0;
      async_q3 <= 1'b0;
      src_tick <= 1'b0;
    end else begin
      bus_half <= next_bus_half;
      alt_q3 <= alternate_clock_source;
      alt_q2 <= alt_q3;
      alt_q <= alt_q2;
      async_q3 <= converter_async_clock;
      async_q2 <= async_q3;
      async_q <= async_q2;
      src_tick <= next_src_tick;
    end
  end

  acp_clk_divider u_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .src_tick(src_tick),
    .divide(cfg.clock_divide_select),
    .div_tick(div_tick)
  );

  // converter clock is the divided enable; one clk wide pulse per period
  always_comb begin
    next_converter_clock = div_tick;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      converter_clock <= 1'b0;
    end else begin
      converter_clock <= next_converter_clock;
    end
  end

  logic [NUM_PINS-1:0] pin_bits;
  assign pin_bits = {pin_mid, pin_low};

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      acp_pin_gate u_gate (
        .clk(clk),
        .sys_rst(sys_rst),
        .disable_bit(pin_bits[g]),
        .port_in(port_in[g]),
        .ctl(pin_ctl[g]),
        .port_read(port_read[g])
      );
    end
  endgenerate
endmodule

/* File: sim/acp_partner_model.sv */
`timescale 1ns/10ps
module acp_partner_model (
  input wire logic clk,
  output logic [15:0] port_in,
  output logic alternate_clock_source,
  output logic converter_async_clock,
  output logic result_written
);
  logic [2:0] tick;
  initial begin
    tick = 3'h0;
    port_in = 16'hA5C3;
    result_written = 1'b0;
  end
  always @(posedge clk) begin
    tick <= tick + 3'h1;
  end
  // alternate source runs at clk/4, async at clk/8, so each source gives its own pulse rate
  always_comb begin
    alternate_clock_source = tick[1];
    converter_async_clock = tick[2];
  end
  task automatic store_result();
    result_written <= 1'b1;
    @(posedge clk);
    result_written <= 1'b0;
  endtask
endmodule

/* File: sim/acp_adc_config_sva.sv */
`timescale 1ns/10ps
module acp_adc_config_sva #(
  parameter int NUM_PINS = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic result_written,
  input wire logic [7:0] reg_rdata,
  input wire acp_pkg::acp_config_t cfg,
  input wire logic result_invalid,
  input wire acp_pkg::acp_pin_ctl_t [NUM_PINS-1:0] pin_ctl,
  input wire logic [NUM_PINS-1:0] port_read
);
  import acp_pkg::*;
  logic [NUM_PINS-1:0] hiz;
  logic agree;
  always_comb begin
    agree = 1'b1;
    for (int i = 0; i < NUM_PINS; i++) begin
      hiz[i] = pin_ctl[i].output_hiz;
      agree = agree & (pin_ctl[i] == {3{hiz[i]}});
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_cfg_write; reg_wr && reg_addr == ACP_OFS_CONFIG |=> cfg == $past(reg_wdata); endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
  property p_cfg_read; reg_rd && reg_addr == ACP_OFS_CONFIG |=> reg_rdata == $past(cfg); endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");
  // a second write to the same place one cycle later supersedes the first
  property p_pin_low; reg_wr && reg_addr == ACP_OFS_PIN_LOW ##1 !(reg_wr && reg_addr == ACP_OFS_PIN_LOW)
    |=> hiz[7:0] == $past(reg_wdata, 2); endproperty
  a_pin_low: assert property (p_pin_low) else $error("low pins wrong");
  property p_pin_mid; reg_wr && reg_addr == ACP_OFS_PIN_MID ##1 !(reg_wr && reg_addr == ACP_OFS_PIN_MID)
    |=> hiz[15:8] == $past(reg_wdata, 2); endproperty
  a_pin_mid: assert property (p_pin_mid) else $error("mid pins wrong");
  property p_pin_agree; agree; endproperty
  a_pin_agree: assert property (p_pin_agree) else $error("pin controls disagree");
  property p_read_zero; (hiz & $past(hiz) & port_read) == '0; endproperty
  a_read_zero: assert property (p_read_zero) else $error("disabled pin reads one");
  property p_reset; $fell(sys_rst) |-> cfg == ACP_RST_CONFIG && hiz == '0 && !result_invalid; endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_mode_inv; reg_wr && reg_addr == ACP_OFS_CONFIG && reg_wdata[3:2] != cfg.mode_select |=> result_invalid;
  endproperty
  a_mode_inv: assert property (p_mode_inv) else $error("result not invalidated");
  property p_inv_clear; result_written && !reg_wr && !$past(reg_wr) |=> !result_invalid; endproperty
  a_inv_clear: assert property (p_inv_clear) else $error("invalid not cleared");
endmodule
bind acp_adc_config acp_adc_config_sva #(.NUM_PINS(NUM_PINS)) i_acp_adc_config_sva (.clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .result_written, .reg_rdata, .cfg, .result_invalid, .pin_ctl, .port_read);

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import acp_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic alternate_clock_source, converter_async_clock, result_written, converter_clock, result_invalid, mode_reserved;
  logic [15:0] port_in, port_read;
  logic [7:0] reg_rdata;
  acp_config_t cfg;
  acp_pin_ctl_t [15:0] pin_ctl;
  int num_errors = 0;
  int samples_checked = 0;
  int pulses;
  logic [7:0] cv [5] = '{8'h80, 8'h70, 8'h04, 8'h0C, 8'h0B};
  logic [7:0] dv [7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h02, 8'h03};
  int ex [7] = '{64, 32, 16, 8, 32, 16, 8};
  always #4 clk = ~clk;
  acp_adc_config i_acp_adc_config (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .alternate_clock_source,
    .converter_async_clock, .result_written, .port_in, .reg_rdata, .cfg, .converter_clock, .result_invalid,
    .mode_reserved, .pin_ctl, .port_read);
  acp_partner_model i_acp_partner_model (.clk, .port_in, .alternate_clock_source, .converter_async_clock,
    .result_written);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe: look mid-cycle, then end on an edge
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(16'(reg_rdata), 16'(exp));
    @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    num_errors++;
    results();
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ACP_OFS_CONFIG, ACP_RST_CONFIG);
    rd(ACP_OFS_PIN_LOW, ACP_RST_PIN);
    rd(ACP_OFS_PIN_MID, ACP_RST_PIN);
    foreach (cv[i]) begin
      wr(ACP_OFS_CONFIG, cv[i]);
      rd(ACP_OFS_CONFIG, cv[i]);
    end
    i_acp_partner_model.store_result();
    rd(ACP_OFS_STATUS, 8'h00);
    wr(ACP_OFS_CONFIG, 8'h03);
    rd(ACP_OFS_STATUS, 8'h01);
    wr(ACP_OFS_CONFIG, 8'h0F);
    rd(ACP_OFS_STATUS, 8'h03);
    wr(ACP_OFS_STATUS, 8'hFF);
    rd(ACP_OFS_STATUS, 8'h03);
    @(negedge clk);
    chk(16'(mode_reserved), 16'h0001);
    @(posedge clk);
    wr(4'hF, 8'hFF);
    rd(4'hF, ACP_UNMAPPED_READ);
    // steady-state window: after the lag, a 64-cycle count is exact for every divider
    foreach (dv[i]) begin
      wr(ACP_OFS_CONFIG, dv[i]);
      repeat (8) @(posedge clk);
      pulses = 0;
      repeat (64) begin
        @(posedge clk);
        #1 pulses += converter_clock;
      end
      chk(16'(pulses), 16'(ex[i]));
    end
    wr(ACP_OFS_PIN_LOW, 8'h81);
    rd(ACP_OFS_PIN_MID, 8'h00);
    wr(ACP_OFS_PIN_MID, 8'hC2);
    rd(ACP_OFS_PIN_LOW, 8'h81);
    repeat (3) @(posedge clk);
    #1 chk(port_read, 16'hA5C3 & ~16'hC281);
    chk(16'(pin_ctl[15]), 16'h0007);
    chk(16'(pin_ctl[1]), 16'h0000);
    // second reset with non-zero state held, so the reset values are really exercised
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ACP_OFS_CONFIG, ACP_RST_CONFIG);
    rd(ACP_OFS_PIN_MID, ACP_RST_PIN);
    rd(ACP_OFS_STATUS, 8'h00);
    #1 chk(16'(pin_ctl[15]), 16'h0000);
    results();
  end
endmodule
